// ### logic/bbg_boot_bus_ctrl.sv
// Boot sequencing and external bus request / grant control
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module bbg_boot_bus_ctrl (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Device pins
  input  wire logic        chip_reset_n,
  input  wire logic [2:0]  mode_pins,
  input  wire logic        emulator_enable,
  input  wire logic        emulator_reset_n,
  input  wire logic        bus_request_n,
  input  wire logic        emulator_bus_request_n,
  output logic             bus_grant_n,
  output logic             bus_grant_oe,
  output logic             emulator_bus_grant_n,
  output logic             grant_hung_n,
  output logic             bus_drive_en,
  // Core side
  input  wire logic        ext_access_busy,
  input  wire logic        ext_access_needed,
  input  wire logic        core_ready,
  input  wire logic        host_pm0_written,
  output logic             core_run,
  output logic             core_restart,
  output logic [13:0]      restart_address,
  output logic             host_memory_mode,
  output logic             dma_done_irq
);
  // Reset and request pins selected by emulator enable
  logic sel_reset_n;
  logic sel_req;
  assign sel_reset_n = emulator_enable ? emulator_reset_n : chip_reset_n;
  assign sel_req     = emulator_enable ? !emulator_bus_request_n : !bus_request_n;

  logic             rst_q;
  logic [2:0]       mode_q;
  bbg_pkg::bbg_state_t st_q;
  logic             dma_transfer_direction_q;
  logic [7:0]       external_page_start_q;
  logic [13:0]      internal_start_address_q;
  logic [13:0]      external_start_address_q;
  logic [1:0]       transfer_format_q;
  logic [13:0]      transfer_word_counter_q;
  logic             dma_context_reset_q;
  logic             run_go_q;
  logic [1:0]       word_cyc_q;
  logic             granted_q;
  logic             held_q;

  logic rst_fall;
  logic apb_wr;
  logic word_done;
  logic dma_active;
  assign rst_fall   = rst_q && sel_reset_n;
  assign apb_wr     = psel && penable && pwrite;
  assign dma_active = transfer_word_counter_q != 14'h0000;
  assign word_done  = dma_active && word_cyc_q == 2'(bbg_pkg::WORD_CYCLES - 1);

  // Chip reset tracked as a level; emulator reset is the same full reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q <= 1'b1;
    end else begin
      rst_q <= !sel_reset_n;
    end
  end

  // Mode pins latched at reset release only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 3'h0;
    end else if (rst_fall) begin
      mode_q <= mode_pins;
    end
  end

  logic boot_byte;
  logic boot_host;
  assign boot_byte = mode_pins == bbg_pkg::MODE_BYTE_FULL ||
                     mode_pins == bbg_pkg::MODE_BYTE_HOST;
  assign boot_host = mode_pins == bbg_pkg::MODE_HOST_PORT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_memory_mode <= 1'b0;
    end else if (rst_fall) begin
      host_memory_mode <= mode_pins[2];
    end
  end

  // Byte DMA setup registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_transfer_direction_q <= 1'b0;
      external_page_start_q    <= 8'h00;
      internal_start_address_q <= 14'h0000;
      external_start_address_q <= 14'h0000;
      transfer_format_q        <= bbg_pkg::FORMAT_PM24;
      dma_context_reset_q      <= 1'b0;
      run_go_q                 <= 1'b0;
    end else if (rst_q) begin
      dma_transfer_direction_q <= 1'b0;
      external_page_start_q    <= 8'h00;
      internal_start_address_q <= 14'h0000;
      external_start_address_q <= 14'h0000;
      transfer_format_q        <= bbg_pkg::FORMAT_PM24;
      dma_context_reset_q      <= boot_byte;
      run_go_q                 <= 1'b0;
    end else if (apb_wr) begin
      case (paddr)
        bbg_pkg::ADDR_CONTROL: begin
          run_go_q                 <= pwdata[bbg_pkg::CTL_RUN_GO];
          dma_context_reset_q      <= pwdata[bbg_pkg::CTL_CTX_RESET];
          dma_transfer_direction_q <= pwdata[bbg_pkg::CTL_DIRECTION];
        end
        bbg_pkg::ADDR_INT_START: internal_start_address_q <= pwdata[13:0];
        bbg_pkg::ADDR_EXT_START: external_start_address_q <= pwdata[13:0];
        bbg_pkg::ADDR_PAGE:      external_page_start_q    <= pwdata[7:0];
        bbg_pkg::ADDR_FORMAT:    transfer_format_q        <= pwdata[1:0];
        default: begin
        end
      endcase
    end else if (st_q == bbg_pkg::BBG_ST_RUN && !dma_active) begin
      dma_context_reset_q <= dma_context_reset_q;
    end
  end

  // Word counter; a word costs WORD_CYCLES byte accesses, bus grant stalls it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_word_counter_q <= 14'h0000;
      word_cyc_q              <= 2'h0;
    end else if (rst_q) begin
      transfer_word_counter_q <= boot_byte ? bbg_pkg::BOOT_WORD_COUNT : 14'h0000;
      word_cyc_q              <= 2'h0;
    end else if (apb_wr && paddr == bbg_pkg::ADDR_WORD_COUNT) begin
      transfer_word_counter_q <= pwdata[13:0];
      word_cyc_q              <= 2'h0;
    end else if (dma_active && !granted_q && !ext_access_busy) begin
      word_cyc_q <= word_done ? 2'h0 : word_cyc_q + 2'h1;
      if (word_done) begin
        transfer_word_counter_q <= transfer_word_counter_q - 14'h0001;
      end
    end
  end

  // Completion pulse when the counter reaches zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_done_irq <= 1'b0;
    end else begin
      dma_done_irq <= word_done && !granted_q && !ext_access_busy && !rst_q &&
                      transfer_word_counter_q == 14'h0001 &&
                      !(apb_wr && paddr == bbg_pkg::ADDR_WORD_COUNT);
    end
  end

  // Sequencer: reset, boot hold, run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q         <= bbg_pkg::BBG_ST_RESET;
      core_restart <= 1'b0;
    end else begin
      core_restart <= 1'b0;
      if (rst_q) begin
        st_q <= bbg_pkg::BBG_ST_RESET;
        if (sel_reset_n) begin
          st_q <= (boot_byte || boot_host) ? bbg_pkg::BBG_ST_BOOT
                                           : bbg_pkg::BBG_ST_RUN;
          core_restart <= !(boot_byte || boot_host);
        end
      end else begin
        case (st_q)
          bbg_pkg::BBG_ST_BOOT: begin
            if ((mode_q == bbg_pkg::MODE_HOST_PORT && host_pm0_written) ||
                (mode_q != bbg_pkg::MODE_HOST_PORT && !dma_active)) begin
              st_q         <= bbg_pkg::BBG_ST_RUN;
              core_restart <= 1'b1;
            end
          end
          bbg_pkg::BBG_ST_RUN: begin
            // Software started transfer with context reset: hold and restart
            if (dma_active && dma_context_reset_q && mode_q != bbg_pkg::MODE_HOST_PORT) begin
              st_q <= bbg_pkg::BBG_ST_BOOT;
            end
          end
          default: st_q <= bbg_pkg::BBG_ST_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_address <= 14'h0000;
    end else begin
      restart_address <= bbg_pkg::START_ADDRESS;
    end
  end

  // Bus grant: taken only when no external access runs, so a
  // two-access instruction is split in the gap between accesses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      granted_q <= 1'b0;
    end else if (!sel_req) begin
      granted_q <= 1'b0;
    end else if (!ext_access_busy) begin
      granted_q <= 1'b1;
    end
  end

  // Grant taken this cycle or held; execution halts with it, not a cycle later
  logic grant_now;
  logic stall_grant;
  assign grant_now   = sel_req && (granted_q || !ext_access_busy);
  // Stall when granted, unless the go option lets it run until it needs the bus
  assign stall_grant = grant_now && (!run_go_q || ext_access_needed);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_q <= 1'b0;
    end else begin
      held_q <= granted_q && sel_req && core_ready && (!run_go_q || ext_access_needed) &&
                st_q == bbg_pkg::BBG_ST_RUN && !rst_q;
    end
  end

  // Pin outputs, all from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_grant_n          <= 1'b1;
      bus_grant_oe         <= 1'b1;
      emulator_bus_grant_n <= 1'b1;
      grant_hung_n         <= 1'b1;
      bus_drive_en         <= 1'b0;
      core_run             <= 1'b0;
    end else begin
      bus_grant_n          <= !(grant_now && !emulator_enable);
      bus_grant_oe         <= !emulator_enable;
      emulator_bus_grant_n <= !(grant_now && emulator_enable);
      grant_hung_n         <= !(held_q && sel_req);
      bus_drive_en         <= !grant_now;
      core_run             <= !rst_q && sel_reset_n && st_q == bbg_pkg::BBG_ST_RUN &&
                              !(stall_grant && sel_req);
    end
  end

  // APB read side, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable) begin
        pslverr <= paddr > bbg_pkg::ADDR_FORMAT || paddr[1:0] != 2'h0;
        case (paddr)
          bbg_pkg::ADDR_CONTROL:
            prdata <= {29'h0, dma_transfer_direction_q, dma_context_reset_q, run_go_q};
          bbg_pkg::ADDR_STATUS:
            prdata <= {24'h0, mode_q, host_memory_mode, granted_q, dma_active,
                       st_q == bbg_pkg::BBG_ST_RUN, st_q == bbg_pkg::BBG_ST_BOOT};
          bbg_pkg::ADDR_WORD_COUNT: prdata <= {18'h0, transfer_word_counter_q};
          bbg_pkg::ADDR_INT_START:  prdata <= {18'h0, internal_start_address_q};
          bbg_pkg::ADDR_EXT_START:  prdata <= {18'h0, external_start_address_q};
          bbg_pkg::ADDR_PAGE:       prdata <= {24'h0, external_page_start_q};
          bbg_pkg::ADDR_FORMAT:     prdata <= {30'h0, transfer_format_q};
          default:                  prdata <= 32'h0;
        endcase
      end
    end
  end

  // Grant follows request within one cycle when the bus is idle
  idle_grant_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_req && !ext_access_busy && !emulator_enable) |=> !bus_grant_n)
    else $error("grant missing after idle request");

  busy_grant_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!granted_q && ext_access_busy) |=> bus_grant_n && emulator_bus_grant_n)
    else $error("grant given during external access");

  release_grant_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sel_req |=> bus_grant_n && emulator_bus_grant_n && bus_drive_en)
    else $error("grant held after request withdrawn");

  hung_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sel_req |=> grant_hung_n)
    else $error("grant hung left after release");

  emu_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    emulator_enable |=> !bus_grant_oe)
    else $error("normal grant driven under emulation");

  boot_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rst_q && boot_byte) |=> transfer_word_counter_q == bbg_pkg::BOOT_WORD_COUNT)
    else $error("boot word count not preset");

  boot_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == bbg_pkg::BBG_ST_BOOT) |=> !core_run)
    else $error("core ran during boot");

  ctx_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == bbg_pkg::BBG_ST_BOOT && !rst_q && mode_q != bbg_pkg::MODE_HOST_PORT &&
     !dma_active) |=> core_restart && st_q == bbg_pkg::BBG_ST_RUN)
    else $error("no restart after boot");
endmodule : bbg_boot_bus_ctrl

// ### inc/bbg_pkg.sv
// Constants and types for the boot and bus grant control block
// Operation
// - Boot method chosen after reset from three mode pins
// - Byte-DMA boot starts when reset is released
// - Boot reset clears direction, page, addresses, format to zero
// - Boot reset loads word counter with 32
// - Boot reset sets context-reset bit; execution held until loaded
// - After boot words loaded, execution begins at address 0
// - Host-select mode boots 32 words by byte DMA, host memory mode
// - Middle-pin mode: no boot, run from external 0, full memory
// - No-boot mode leaves byte DMA to software, no waiting
// - Host port boot holds execution until program word 0 written
// - Idle bus request: next cycle float bus, grant, halt
// - Run-until-external option keeps executing while granted
// - Request during access: grant the cycle after access completes
// - Two-access instruction: grant between the two accesses
// - Request withdrawn: drop grant, re-drive bus, resume
// - Bus request honoured always, even in boot and reset
// - Grant-hung asserted when ready to execute but bus granted
// - On release drop grant and grant-hung, then do pending access
// - Emulator enable swaps in emulator reset, request, grant pins
// - Emulator reset is a full reset and resamples mode pins
// - Context-reset set: stop during DMA, restart at 0 at end; in host port mode the code does not stop
// - Word counter decrements per transfer; zero means done, interrupt
package bbg_pkg;
  typedef enum logic [1:0] {
    BBG_BOOT_BYTE_FULL,
    BBG_BOOT_NONE,
    BBG_BOOT_BYTE_HOST,
    BBG_BOOT_HOST_PORT
  } bbg_boot_t;

  typedef enum {
    BBG_ST_RESET,
    BBG_ST_BOOT,
    BBG_ST_RUN
  } bbg_state_t;

  localparam logic [2:0]  MODE_BYTE_FULL   = 3'h0;
  localparam logic [2:0]  MODE_NONE        = 3'h2;
  localparam logic [2:0]  MODE_BYTE_HOST   = 3'h4;
  localparam logic [2:0]  MODE_HOST_PORT   = 3'h5;
  localparam logic [13:0] BOOT_WORD_COUNT  = 14'h0020;
  localparam logic [13:0] START_ADDRESS    = 14'h0000;
  localparam logic [1:0]  FORMAT_PM24      = 2'h0;
  localparam int          WORD_CYCLES      = 3;

  // Register map, word aligned byte addresses
  localparam logic [7:0]  ADDR_CONTROL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS      = 8'h04;
  localparam logic [7:0]  ADDR_WORD_COUNT  = 8'h08;
  localparam logic [7:0]  ADDR_INT_START   = 8'h0c;
  localparam logic [7:0]  ADDR_EXT_START   = 8'h10;
  localparam logic [7:0]  ADDR_PAGE        = 8'h14;
  localparam logic [7:0]  ADDR_FORMAT      = 8'h18;

  // Control fields
  localparam int          CTL_RUN_GO       = 0;
  localparam int          CTL_CTX_RESET    = 1;
  localparam int          CTL_DIRECTION    = 2;
endpackage : bbg_pkg

// ### verif/bbg_bus_master_model.sv
// External bus master that borrows the memory bus for a while
`timescale 1ns/1ns
module bbg_bus_master_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control from the bench
  input  wire logic       go,
  input  wire logic [7:0] hold_cycles,
  // Bus handshake
  input  wire logic       grant_n,
  output logic            request_n
);
  logic [7:0] cnt_q;

  // Request held for the whole time the bus is in use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_n <= 1'h1;
      cnt_q     <= 8'h00;
    end else if (request_n && go) begin
      request_n <= 1'h0;
      cnt_q     <= hold_cycles;
    end else if (!request_n && !grant_n) begin
      // Count only granted cycles, so a slow grant never shortens the use
      if (cnt_q == 8'h00) begin
        request_n <= 1'h1;
      end else begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : bbg_bus_master_model

// ### verif/tb_top.sv
// Self-checking bench for the boot and bus grant control block
`timescale 1ns/1ns
module tb_top;
  typedef struct {
    logic [2:0] mode;
    logic       host;
    int         lo;
    int         hi;
    bit         pm0;
    bit         byte_boot;
  } bbg_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        chip_reset_n, emulator_enable, emulator_reset_n, go, req_n, grant_w;
  logic        bus_grant_n, bus_grant_oe, emulator_bus_grant_n, grant_hung_n;
  logic        bus_drive_en, ext_access_busy, ext_access_needed, core_ready;
  logic        host_pm0_written, core_run, core_restart, host_memory_mode, dma_done_irq;
  logic [2:0]  mode_pins;
  logic [7:0]  paddr;
  logic [13:0] restart_address;
  logic [31:0] pwdata, prdata, rd;
  int          error_cnt, checked, n, restarts, irqs;
  bbg_row_t    rows[4] = '{'{3'h0, 1'h0, 70, 400, 1'b0, 1'b1},
                           '{3'h4, 1'h1, 70, 400, 1'b0, 1'b1},
                           '{3'h5, 1'h1, 0, 20, 1'b1, 1'b0},
                           '{3'h2, 1'h0, 0, 20, 1'b0, 1'b0}};

  // Normal grant pin has a pull-up while floated
  assign grant_w = emulator_enable ? emulator_bus_grant_n : (bus_grant_oe ? bus_grant_n : 1'h1);

  bbg_boot_bus_ctrl u_bbg_boot_bus_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_reset_n(chip_reset_n), .mode_pins(mode_pins), .emulator_enable(emulator_enable),
    .emulator_reset_n(emulator_reset_n), .bus_request_n(emulator_enable | req_n),
    .emulator_bus_request_n(!emulator_enable | req_n), .bus_grant_n(bus_grant_n),
    .bus_grant_oe(bus_grant_oe), .emulator_bus_grant_n(emulator_bus_grant_n),
    .grant_hung_n(grant_hung_n), .bus_drive_en(bus_drive_en),
    .ext_access_busy(ext_access_busy), .ext_access_needed(ext_access_needed),
    .core_ready(core_ready), .host_pm0_written(host_pm0_written), .core_run(core_run),
    .core_restart(core_restart), .restart_address(restart_address),
    .host_memory_mode(host_memory_mode), .dma_done_irq(dma_done_irq));

  bbg_bus_master_model u_bbg_bus_master_model (
    .pclk(pclk), .presetn(presetn), .go(go), .hold_cycles(8'h06), .grant_n(grant_w),
    .request_n(req_n));

  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    restarts += (core_restart === 1'h1);
    irqs     += (dma_done_irq === 1'h1);
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // Request stands until pready is seen at a rising edge; watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wait_grant(input logic lvl);
    n = 0;
    while (grant_w !== lvl && n < 40) begin
      @(negedge pclk);
      n++;
    end
  endtask : wait_grant

  task automatic borrow();
    @(posedge pclk);
    go <= 1'h1;
    @(posedge pclk);
    go <= 1'h0;
  endtask : borrow

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end

  initial begin
    {psel, penable, pwrite, go, ext_access_busy, ext_access_needed} = 6'h00;
    {host_pm0_written, emulator_enable, presetn} = 3'h0;
    {chip_reset_n, emulator_reset_n, core_ready} = 3'h7;
    paddr = 8'h00;
    pwdata = 32'h0;
    mode_pins = 3'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      mode_pins    <= rows[i].mode;
      chip_reset_n <= 1'h0;
      repeat (3) @(posedge pclk);
      chip_reset_n <= 1'h1;
      restarts = 0;
      irqs = 0;
      if (rows[i].byte_boot) begin
        apb(1'h0, bbg_pkg::ADDR_CONTROL, 32'h0);
        check("ctx and dir", rd[2:1], 2'h1);
        apb(1'h0, bbg_pkg::ADDR_FORMAT, 32'h0);
        check("format", rd, 32'h0);
        apb(1'h0, bbg_pkg::ADDR_PAGE, 32'h0);
        check("page", rd, 32'h0);
        apb(1'h0, bbg_pkg::ADDR_WORD_COUNT, 32'h0);
        check("count", rd > 0 && rd <= 32, 1'h1);
      end
      if (rows[i].pm0) begin
        repeat (150) @(negedge pclk);
        check("held", core_run, 1'h0);
        @(posedge pclk);
        host_pm0_written <= 1'h1;
        @(posedge pclk);
        host_pm0_written <= 1'h0;
      end
      n = 0;
      while (core_run !== 1'h1 && n < 400) begin
        @(negedge pclk);
        n++;
      end
      check("boot time", n >= rows[i].lo && n <= rows[i].hi, 1'h1);
      check("host mode", host_memory_mode, rows[i].host);
      check("restart addr", restart_address, 14'h0000);
      check("done irq", irqs > 0, rows[i].byte_boot);
      if (rows[i].byte_boot) begin
        check("restarts", restarts, 32'h1);
      end
      apb(1'h0, bbg_pkg::ADDR_STATUS, 32'h0);
      check("status mode", rd[7:4], {rows[i].mode, rows[i].host});
      $display("test boot mode %h done", rows[i].mode);
    end
    mode_pins <= 3'h4;
    repeat (5) @(negedge pclk);
    check("mode held", host_memory_mode, 1'h0);
    @(posedge pclk);
    mode_pins <= 3'h2;
    irqs = 0;
    apb(1'h1, bbg_pkg::ADDR_WORD_COUNT, 32'h4);
    n = 0;
    repeat (30) begin
      @(negedge pclk);
      n += (core_run !== 1'h1);
    end
    check("no wait", n, 32'h0);
    check("sw irq", irqs, 32'h1);
    apb(1'h0, bbg_pkg::ADDR_WORD_COUNT, 32'h0);
    check("count zero", rd, 32'h0);
    // Software transfer with context reset: hold, then restart at 0
    restarts = 0;
    apb(1'h1, bbg_pkg::ADDR_CONTROL, 32'h2);
    apb(1'h1, bbg_pkg::ADDR_WORD_COUNT, 32'h2);
    repeat (3) @(negedge pclk);
    check("ctx hold", core_run, 1'h0);
    repeat (20) @(negedge pclk);
    check("ctx restart", restarts, 32'h1);
    check("ctx resume", core_run, 1'h1);
    apb(1'h1, bbg_pkg::ADDR_CONTROL, 32'h0);
    $display("test software dma done");
    borrow();
    wait_grant(1'h0);
    check("grant lat", n <= 3, 1'h1);
    check("drive off", bus_drive_en, 1'h0);
    check("halted", core_run, 1'h0);
    repeat (3) @(negedge pclk);
    check("hung", grant_hung_n, 1'h0);
    wait_grant(1'h1);
    @(negedge pclk);
    check("drive on", bus_drive_en, 1'h1);
    check("hung off", grant_hung_n, 1'h1);
    repeat (2) @(negedge pclk);
    check("resumed", core_run, 1'h1);
    $display("test grant done");
    @(posedge pclk);
    ext_access_busy <= 1'h1;
    borrow();
    repeat (5) @(negedge pclk);
    check("wait access", grant_w, 1'h1);
    @(posedge pclk);
    ext_access_busy <= 1'h0;
    wait_grant(1'h0);
    check("after access", n <= 3, 1'h1);
    wait_grant(1'h1);
    apb(1'h1, bbg_pkg::ADDR_CONTROL, 32'h1);
    borrow();
    wait_grant(1'h0);
    @(negedge pclk);
    check("go mode run", core_run, 1'h1);
    @(posedge pclk);
    ext_access_needed <= 1'h1;
    repeat (3) @(negedge pclk);
    check("go mode stop", core_run, 1'h0);
    wait_grant(1'h1);
    @(posedge pclk);
    ext_access_needed <= 1'h0;
    apb(1'h1, bbg_pkg::ADDR_CONTROL, 32'h0);
    chip_reset_n <= 1'h0;
    borrow();
    wait_grant(1'h0);
    check("grant in reset", n <= 3, 1'h1);
    wait_grant(1'h1);
    @(posedge pclk);
    chip_reset_n <= 1'h1;
    emulator_enable <= 1'h1;
    borrow();
    wait_grant(1'h0);
    check("emu grant", n <= 3, 1'h1);
    check("normal float", bus_grant_oe, 1'h0);
    wait_grant(1'h1);
    @(posedge pclk);
    mode_pins <= 3'h4;
    emulator_reset_n <= 1'h0;
    repeat (3) @(posedge pclk);
    emulator_reset_n <= 1'h1;
    repeat (5) @(negedge pclk);
    check("emu reset mode", host_memory_mode, 1'h1);
    @(posedge pclk);
    emulator_enable <= 1'h0;
    $display("test bus awkward cases done");
    apb(1'h0, 8'h1c, 32'h0);
    check("unmapped err", err, 1'h1);
    apb(1'h1, 8'h05, 32'h1);
    check("unaligned err", err, 1'h1);
    presetn <= 1'h0;
    @(negedge pclk);
    check("reset outs", {bus_grant_n, grant_hung_n, bus_drive_en, core_run, pready}, 5'h18);
    $display("test reset done");
    complete_run();
  end
endmodule : tb_top
